/* File: sbr_sys.sv */
// System end: bus reset and ID configuration, frequency select, priority agent, presence.
//
// Functional notes
// - Priority line active stops new non-locked requests.
// - Priority agent holds line until its outstanding requests, counted up to 15, complete.
// - Select low bit set 100 MHz, clear 66.
// - Processor ignores upper frequency select bit.
// - All agents share one bus frequency.
// - Processor runs only at its specified rate.
// - Central agent asserts request zero during configuration.
// - Processor samples request pin at reset release.
// - Processor pin drives request zero when wanting.
// - Presence output is ground inside processor.
// - Presence alone decides occupancy.
// - Low presence, non-all-ones code means core.
`timescale 1ns/1ps
module sbr_sys (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	sbr_bus_if.sys bus,
	input wire logic I_SEL_100,
	input wire logic I_CFG_START,
	input wire logic I_PRI_REQ,
	input wire logic I_PRI_DONE,
	output logic O_CFG_DONE,
	output logic O_FREQ_100,
	output logic O_PRI_OWNS,
	output logic O_AGENTS_MAY_REQ,
	output logic O_CPU_WANTS_BUS,
	output logic O_SOCKET_OCCUPIED,
	output logic O_CORE_PRESENT
);
	typedef struct packed {
		sbr_pkg::sbr_cfg_state_t st;
		logic [sbr_pkg::CFG_CNT_W-1:0] cnt;
		logic sel_100;
		logic rst_n;
		logic br_o;
		logic br_oe_n;
		logic priority_bus_request_n_n;
		logic [sbr_pkg::PRI_CNT_W-1:0] pri_cnt;
		logic [1:0] br_sync;
		logic [1:0] pres_sync;
		logic [3:0] vid_s1;
		logic [3:0] vid_s2;
		logic cfg_done;
		logic may_req;
		logic cpu_wants;
		logic occupied;
		logic core;
		logic pri_owns;
		logic [1:0] own_pull;
	} sbr_sys_state_t;

	sbr_sys_state_t s_reg;
	sbr_sys_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		s_next.br_sync = {s_reg.br_sync[0], bus.system_bus_request0_n};
		s_next.pres_sync = {s_reg.pres_sync[0], bus.processor_present_n};
		s_next.vid_s1 = bus.voltage_id_code;
		s_next.vid_s2 = s_reg.vid_s1;

		unique case (s_reg.st)
			sbr_pkg::SBR_ST_RESET:
			begin
				// The rate may only change while every agent is held in reset.
				s_next.sel_100 = I_SEL_100 ? sbr_pkg::BSEL_100 : sbr_pkg::BSEL_66;
				s_next.rst_n = 1'h0;
				s_next.br_o = 1'h0;
				s_next.br_oe_n = 1'h0;
				s_next.cfg_done = 1'h0;
				if (s_reg.cnt == sbr_pkg::CFG_RESET_LAST)
				begin
					s_next.st = sbr_pkg::SBR_ST_RELEASE;
					s_next.cnt = sbr_pkg::CFG_CNT_ZERO;
					s_next.rst_n = 1'h1;
				end
				else
				begin
					s_next.cnt = s_reg.cnt + 8'h01;
				end
			end
			sbr_pkg::SBR_ST_RELEASE:
			begin
				// The ID level stays on the line past the release edge.
				if (s_reg.cnt == sbr_pkg::CFG_HOLD_LAST)
				begin
					s_next.st = sbr_pkg::SBR_ST_RUN;
					s_next.cnt = sbr_pkg::CFG_CNT_ZERO;
					s_next.br_oe_n = 1'h1;
					s_next.cfg_done = 1'h1;
				end
				else
				begin
					s_next.cnt = s_reg.cnt + 8'h01;
				end
			end
			sbr_pkg::SBR_ST_RUN:
			begin
				if (I_CFG_START)
				begin
					s_next.st = sbr_pkg::SBR_ST_RESET;
					s_next.cnt = sbr_pkg::CFG_CNT_ZERO;
					s_next.rst_n = 1'h0;
					s_next.br_oe_n = 1'h0;
					s_next.cfg_done = 1'h0;
				end
			end
			default:
			begin
				s_next.st = sbr_pkg::SBR_ST_RESET;
				s_next.cnt = sbr_pkg::CFG_CNT_ZERO;
			end
		endcase

		// Outstanding priority requests, counted up to 15; the line stays active until all counted requests complete.
		if (s_next.st != sbr_pkg::SBR_ST_RUN)
		begin
			s_next.pri_cnt = sbr_pkg::PRI_CNT_ZERO;
		end
		else if (I_PRI_REQ && !I_PRI_DONE)
		begin
			if (s_reg.pri_cnt != sbr_pkg::PRI_CNT_MAX)
			begin
				s_next.pri_cnt = s_reg.pri_cnt + 4'h1;
			end
		end
		else if (!I_PRI_REQ && I_PRI_DONE)
		begin
			if (s_reg.pri_cnt != sbr_pkg::PRI_CNT_ZERO)
			begin
				s_next.pri_cnt = s_reg.pri_cnt - 4'h1;
			end
		end
		s_next.priority_bus_request_n_n = (s_next.pri_cnt == sbr_pkg::PRI_CNT_ZERO);
		s_next.pri_owns = ~s_next.priority_bus_request_n_n;
		// Other agents may request again as soon as the line is released.
		s_next.may_req = s_next.priority_bus_request_n_n & s_next.cfg_done;

		// The line reaches us through two flip-flops, so our own pull is masked as long.
		s_next.own_pull = {s_reg.own_pull[0], ~s_reg.br_oe_n};
		s_next.cpu_wants = s_reg.cfg_done & ~s_reg.br_sync[1] & ~s_reg.own_pull[1];
		// A grounded presence pin means the socket holds a part.
		s_next.occupied = (s_reg.pres_sync[1] == sbr_pkg::PRESENT_LVL);
		s_next.core = s_next.occupied & (s_reg.vid_s2 != sbr_pkg::VID_NO_CORE);
	end

	always_ff @(posedge I_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			s_reg <= '0;
			s_reg.st <= sbr_pkg::SBR_ST_RESET;
			s_reg.sel_100 <= sbr_pkg::BSEL_RESET[sbr_pkg::BSEL_FREQ_BIT];
			s_reg.priority_bus_request_n_n <= 1'h1;
			s_reg.br_sync <= 2'h3;
			s_reg.pres_sync <= 2'h3;
			s_reg.vid_s1 <= sbr_pkg::VID_NO_CORE;
			s_reg.vid_s2 <= sbr_pkg::VID_NO_CORE;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign bus.priority_bus_request_n = s_reg.priority_bus_request_n_n;
	// The upper select bit only sits at its pulled-up level.
	assign bus.bus_freq_select = {sbr_pkg::BSEL_UPPER_LVL, s_reg.sel_100};
	assign bus.bus_reset_n = s_reg.rst_n;
	assign bus.sys_request0_n_o = s_reg.br_o;
	assign bus.sys_request0_n_oe_n = s_reg.br_oe_n;
	assign O_CFG_DONE = s_reg.cfg_done;
	assign O_FREQ_100 = s_reg.sel_100;
	assign O_PRI_OWNS = s_reg.pri_owns;
	assign O_AGENTS_MAY_REQ = s_reg.may_req;
	assign O_CPU_WANTS_BUS = s_reg.cpu_wants;
	assign O_SOCKET_OCCUPIED = s_reg.occupied;
	assign O_CORE_PRESENT = s_reg.core;
endmodule : sbr_sys

/* File: sbr_pkg.sv */
// Shared constants and types for the system bus request and configuration ends.
package sbr_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	// Bus reset is held this long while the central agent drives the agent ID.
	localparam int CFG_RESET_TIME_NS = 1000;
	localparam int CFG_RESET_CYC = (CFG_RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// The ID level is held this long past the release of bus reset.
	localparam int CFG_HOLD_TIME_NS = 20;
	localparam int CFG_HOLD_CYC = (CFG_HOLD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CFG_CNT_W = 8;
	localparam logic [CFG_CNT_W-1:0] CFG_RESET_LAST = CFG_CNT_W'(CFG_RESET_CYC - 1);
	localparam logic [CFG_CNT_W-1:0] CFG_HOLD_LAST = CFG_CNT_W'(CFG_HOLD_CYC - 1);
	localparam logic [CFG_CNT_W-1:0] CFG_CNT_ZERO = 8'h00;
	// Frequency select: only the low bit has meaning, set selects 100 MHz.
	localparam int BSEL_W = 2;
	localparam int BSEL_FREQ_BIT = 0;
	localparam logic BSEL_100 = 1'h1;
	localparam logic BSEL_66 = 1'h0;
	localparam logic BSEL_UPPER_LVL = 1'h1;
	localparam logic [BSEL_W-1:0] BSEL_RESET = 2'h3;
	localparam logic DEV_SPEC_100 = 1'h1;
	// Voltage identifier; the all-ones code means no core.
	localparam int VID_W = 4;
	localparam logic [VID_W-1:0] VID_NO_CORE = 4'hF;
	localparam logic [VID_W-1:0] DEV_VID_CODE = 4'h6;
	localparam logic PRESENT_LVL = 1'h0;
	localparam int PRI_CNT_W = 4;
	localparam logic [PRI_CNT_W-1:0] PRI_CNT_ZERO = 4'h0;
	localparam logic [PRI_CNT_W-1:0] PRI_CNT_MAX = 4'hF;
	typedef enum logic [1:0] {
		SBR_ST_RESET = 2'b00,
		SBR_ST_RELEASE = 2'b01,
		SBR_ST_RUN = 2'b10
	} sbr_cfg_state_t;
endpackage : sbr_pkg

/* File: sbr_bus_if.sv */
// Bus pins shared by the processor end and the system end.
`timescale 1ns/1ps
interface sbr_bus_if;
	logic priority_bus_request_n;
	logic [1:0] bus_freq_select;
	logic bus_reset_n;
	logic agent_bus_request_n_o;
	logic agent_bus_request_n_oe_n;
	logic sys_request0_n_o;
	logic sys_request0_n_oe_n;
	logic system_bus_request0_n;
	logic processor_present_n;
	logic [3:0] voltage_id_code;

	// Open-drain request line: low when any enabled driver pulls low.
	assign system_bus_request0_n = ~((~agent_bus_request_n_oe_n & ~agent_bus_request_n_o)
		| (~sys_request0_n_oe_n & ~sys_request0_n_o));

	modport cpu (
		input priority_bus_request_n,
		input bus_freq_select,
		input bus_reset_n,
		input system_bus_request0_n,
		output agent_bus_request_n_o,
		output agent_bus_request_n_oe_n,
		output processor_present_n,
		output voltage_id_code
	);

	modport sys (
		output priority_bus_request_n,
		output bus_freq_select,
		output bus_reset_n,
		output sys_request0_n_o,
		output sys_request0_n_oe_n,
		input system_bus_request0_n,
		input processor_present_n,
		input voltage_id_code
	);
endinterface : sbr_bus_if

/* File: sbr_cpu.sv */
// Processor end: agent ID capture, bus request pin, request gating and presence.
`timescale 1ns/1ps
module sbr_cpu (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	sbr_bus_if.cpu bus,
	input wire logic I_WANT_BUS,
	input wire logic I_NEW_REQ,
	input wire logic I_LOCKED,
	output logic O_AGENT_ID,
	output logic O_ID_VALID,
	output logic O_FREQ_100,
	output logic O_FREQ_OK,
	output logic O_MAY_ISSUE,
	output logic O_REQ_ISSUE
);
	typedef struct packed {
		logic [1:0] priority_bus_request_n_sync;
		logic [1:0] rst_sync;
		logic [1:0] br_sync;
		logic [1:0] bsel_sync;
		logic rst_prev;
		logic agent_id;
		logic id_valid;
		logic freq_100;
		logic freq_ok;
		logic may_issue;
		logic req_issue;
		logic br_o;
		logic br_oe_n;
		logic present_n;
		logic [3:0] vid;
	} sbr_cpu_state_t;

	sbr_cpu_state_t s_reg;
	sbr_cpu_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		s_next.priority_bus_request_n_sync = {s_reg.priority_bus_request_n_sync[0], bus.priority_bus_request_n};
		s_next.rst_sync = {s_reg.rst_sync[0], bus.bus_reset_n};
		s_next.br_sync = {s_reg.br_sync[0], bus.system_bus_request0_n};
		// Only the low select bit is looked at.
		s_next.bsel_sync = {s_reg.bsel_sync[0], bus.bus_freq_select[sbr_pkg::BSEL_FREQ_BIT]};
		s_next.rst_prev = s_reg.rst_sync[1];
		if (!s_reg.rst_sync[1])
		begin
			s_next.id_valid = 1'h0;
		end
		else if (!s_reg.rst_prev)
		begin
			// Release edge of bus reset: the request line level is the agent ID.
			s_next.agent_id = s_reg.br_sync[1];
			s_next.id_valid = 1'h1;
			s_next.freq_100 = s_reg.bsel_sync[1];
			// The device runs only at its own rate, shared by every agent.
			s_next.freq_ok = (s_reg.bsel_sync[1] == sbr_pkg::DEV_SPEC_100);
		end
		// The pin is pulled low whenever ownership of the bus is wanted and the agent ID is valid.
		s_next.br_oe_n = ~(s_next.id_valid & I_WANT_BUS);
		s_next.br_o = 1'h0;
		// New requests wait while the priority line is active, locked ones go on.
		s_next.may_issue = s_next.id_valid & (s_reg.priority_bus_request_n_sync[1] | I_LOCKED);
		s_next.req_issue = I_NEW_REQ & s_next.may_issue;
		s_next.present_n = sbr_pkg::PRESENT_LVL;
		s_next.vid = sbr_pkg::DEV_VID_CODE;
	end

	always_ff @(posedge I_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			s_reg <= '0;
			s_reg.priority_bus_request_n_sync <= 2'h3;
			s_reg.br_sync <= 2'h3;
			s_reg.br_oe_n <= 1'h1;
			s_reg.vid <= sbr_pkg::VID_NO_CORE;
			s_reg.present_n <= 1'h1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign bus.agent_bus_request_n_o = s_reg.br_o;
	assign bus.agent_bus_request_n_oe_n = s_reg.br_oe_n;
	assign bus.processor_present_n = s_reg.present_n;
	assign bus.voltage_id_code = s_reg.vid;
	assign O_AGENT_ID = s_reg.agent_id;
	assign O_ID_VALID = s_reg.id_valid;
	assign O_FREQ_100 = s_reg.freq_100;
	assign O_FREQ_OK = s_reg.freq_ok;
	assign O_MAY_ISSUE = s_reg.may_issue;
	assign O_REQ_ISSUE = s_reg.req_issue;
endmodule : sbr_cpu

/* File: sbr_bus_assertions.sv */
// Checker for the request and configuration pins between the two ends.
`timescale 1ns/1ps
module sbr_bus_assertions (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic priority_bus_request_n,
	input wire logic [1:0] bus_freq_select,
	input wire logic bus_reset_n,
	input wire logic agent_bus_request_n_o,
	input wire logic agent_bus_request_n_oe_n,
	input wire logic sys_request0_n_o,
	input wire logic sys_request0_n_oe_n,
	input wire logic system_bus_request0_n,
	input wire logic processor_present_n,
	input wire logic [3:0] voltage_id_code
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RSTN);
	sequence s_id_hold;
		(!sys_request0_n_oe_n && !sys_request0_n_o) [*4];
	endsequence
	a_id_hold_release: assert property ($rose(bus_reset_n) |-> s_id_hold ##[1:2] sys_request0_n_oe_n)
		else $error("agent ID level not held then released");
	a_reset_length: assert property ($rose(bus_reset_n) |-> !$past(bus_reset_n, 200))
		else $error("bus reset released too early");
	a_reset_id_drive: assert property (!bus_reset_n |-> !system_bus_request0_n)
		else $error("request line not asserted during bus reset");
	a_cpu_pull_low: assert property (!agent_bus_request_n_oe_n |-> !agent_bus_request_n_o && !system_bus_request0_n)
		else $error("processor request does not pull the line low");
	a_present_low: assert property (I_RSTN [*3] |-> !processor_present_n)
		else $error("presence output not low");
	a_vid_code: assert property (I_RSTN [*3] |-> voltage_id_code == sbr_pkg::DEV_VID_CODE)
		else $error("voltage identifier wrong");
	a_sel_upper: assert property (bus_freq_select[1] == sbr_pkg::BSEL_UPPER_LVL)
		else $error("upper select bit moved");
	a_sel_stable: assert property (bus_reset_n && $past(bus_reset_n) |-> $stable(bus_freq_select))
		else $error("select changed while running");
endmodule : sbr_bus_assertions

/* File: system_bus_request_and_config_test.sv */
// Self-checking bench joining the processor end and the system end.
`timescale 1ns/1ps
module system_bus_request_and_config_test;
	logic I_CLK = 1'b0;
	logic I_RSTN = 1'b0;
	logic want = 1'b0, new_req = 1'b0, locked = 1'b0;
	logic sel = 1'b0, cfg_start = 1'b0, pri_req = 1'b0, pri_done = 1'b0;
	logic agent_id, id_valid, freq_c, freq_ok, may_issue, req_issue;
	logic cfg_done, freq_s, pri_owns, may_req, cpu_wants, occupied, core;
	logic issued = 1'b0;
	logic [13:0] e;
	logic [13:0] notes [$];
	event noted;
	int seed = 73;
	int miscompares = 0;
	int n_checks = 0;
	sbr_bus_if bus ();
	sbr_cpu sbr_cpu_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .bus(bus), .I_WANT_BUS(want),
		.I_NEW_REQ(new_req), .I_LOCKED(locked), .O_AGENT_ID(agent_id), .O_ID_VALID(id_valid),
		.O_FREQ_100(freq_c), .O_FREQ_OK(freq_ok), .O_MAY_ISSUE(may_issue),
		.O_REQ_ISSUE(req_issue));
	sbr_sys sbr_sys_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .bus(bus), .I_SEL_100(sel),
		.I_CFG_START(cfg_start), .I_PRI_REQ(pri_req), .I_PRI_DONE(pri_done),
		.O_CFG_DONE(cfg_done), .O_FREQ_100(freq_s), .O_PRI_OWNS(pri_owns),
		.O_AGENTS_MAY_REQ(may_req), .O_CPU_WANTS_BUS(cpu_wants),
		.O_SOCKET_OCCUPIED(occupied), .O_CORE_PRESENT(core));
	sbr_bus_assertions sbr_bus_assertions_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
		.priority_bus_request_n(bus.priority_bus_request_n),
		.bus_freq_select(bus.bus_freq_select), .bus_reset_n(bus.bus_reset_n),
		.agent_bus_request_n_o(bus.agent_bus_request_n_o),
		.agent_bus_request_n_oe_n(bus.agent_bus_request_n_oe_n),
		.sys_request0_n_o(bus.sys_request0_n_o), .sys_request0_n_oe_n(bus.sys_request0_n_oe_n),
		.system_bus_request0_n(bus.system_bus_request0_n),
		.processor_present_n(bus.processor_present_n), .voltage_id_code(bus.voltage_id_code));
	initial forever #2.5 I_CLK = ~I_CLK;
	// Request pulses last one cycle, so they are caught here and read later.
	always @(posedge I_CLK) if (req_issue === 1'b1) issued <= 1'b1;
	task print_verdict();
		$display("checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic cyc(input int n);
		repeat (n) @(negedge I_CLK);
	endtask : cyc
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask : pulse
	task automatic wait_cfg(input logic v);
		int n;
		n = 0;
		while (cfg_done !== v && n < 600)
		begin
			cyc(1);
			n++;
		end
		if (cfg_done !== v)
		begin
			miscompares++;
			print_verdict();
		end
	endtask : wait_cfg
	task automatic note(input logic [13:0] x);
		notes.push_back(x);
		-> noted;
	endtask : note
	function automatic logic [13:0] idle(input logic s);
		return {2'h1, s, s == sbr_pkg::DEV_SPEC_100, 3'h5, s, 6'h17};
	endfunction : idle
	initial forever
	begin
		@(noted);
		while (notes.size() > 0)
		begin
			e = notes.pop_front();
			n_checks++;
			if (e !== {agent_id, id_valid, freq_c, freq_ok, may_issue, issued, cfg_done, freq_s,
				pri_owns, may_req, cpu_wants, occupied, core, bus.system_bus_request0_n})
			begin
				miscompares++;
				$display("unexpected at %0t: got %h expected %h", $time, {agent_id, id_valid,
					freq_c, freq_ok, may_issue, issued, cfg_done, freq_s, pri_owns, may_req,
					cpu_wants, occupied, core, bus.system_bus_request0_n}, e);
			end
		end
	end
	initial
	begin
		sel = 1'($random(seed));
		cyc(8);
		I_RSTN = 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			if (k > 0)
			begin
				sel = k[0];
				pulse(cfg_start);
				wait_cfg(1'b0);
			end
			wait_cfg(1'b1);
			cyc(2);
			note(idle(sel));
		end
		pulse(pri_req);
		pulse(pri_req);
		pulse(pri_done);
		cyc(3);
		pulse(new_req);
		cyc(2);
		note(idle(sel) ^ 14'h0230);
		locked = 1'b1;
		cyc(4);
		pulse(new_req);
		cyc(2);
		note(idle(sel) ^ 14'h0130);
		locked = 1'b0;
		pulse(pri_done);
		issued = 1'b0;
		pulse(pri_done);
		cyc(4);
		pulse(new_req);
		cyc(2);
		note(idle(sel) ^ 14'h0100);
		want = 1'b1;
		cyc(1);
		issued = 1'b0;
		cyc(5);
		note(idle(sel) ^ 14'h0009);
		want = 1'b0;
		cyc(6);
		note(idle(sel));
		cyc(1);
		print_verdict();
	end
endmodule : system_bus_request_and_config_test
